/* File: hw/iod_pkg.sv */
// Purpose: Constants for the I/O board peripheral map decoder
// Assumes: 24-bit host byte address, 16-bit host data bus
// Notes: Map is 512 bytes, relocatable on 512-byte boundaries
package iod_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int MAP_OFS_W = 9;
  localparam int BASE_W = ADDR_W - MAP_OFS_W;
  localparam int NUM_TMR = 3;
  localparam int NUM_PIO = 3;
  localparam int NUM_SER = 2;
  localparam logic [BASE_W-1:0] BASE_RST = 15'h7f80;
  localparam logic [7:0] PERIPH_FIRST = 8'h40;
  localparam logic [7:0] PERIPH_LAST = 8'hbf;
  localparam logic [4:0] SLOT_NULL_LO = 5'h1b;
  localparam logic [4:0] SLOT_NULL_HI = 5'h1f;
  localparam logic [4:0] SLOT_NULL_A = 5'h12;
  localparam logic [4:0] SLOT_NULL_B = 5'h16;
  localparam logic [4:0] SLOT_NULL_C = 5'h0e;
  localparam logic [4:0] SLOT_NULL_D = 5'h0f;
  localparam logic [1:0] SYNC_INIT = 2'h3;
  typedef enum logic [1:0] {
    IOD_IDLE = 2'b00,
    IOD_WAIT = 2'b01,
    IOD_ACK = 2'b10
  } iod_state_t;
endpackage

/* File: hw/iod_decode.sv */
// Purpose: Peripheral map decode, bus cycle and connector signal paths
// Assumes: One host access at a time; peripherals answer with a ready pulse
// Notes: Map base is a static strap sampled after reset release
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - A read of a null location returns zero and ends as a normal cycle.
// RQ2 - A write to a null location ends normally and changes nothing.
// RQ3 - A write to an upper byte stores the low data lane into that location.
// RQ4 - Upper byte accesses never raise a bus error and end normally.
// RQ5 - The map spans 512 bytes, 256 upper and 256 lower byte positions.
// RQ6 - The whole map relocates as one unit to any 512-byte boundary.
// RQ7 - Each timer can count from its own external clock pin.
// RQ8 - Each timer gate input, when asserted, suppresses its external clock.
// RQ9 - Each timer output can be routed onto its own output pin.
// RQ10 - A1 feeds handshake 1, A2 from 2, B1 feeds 3, B2 from 4.
// RQ11 - Terminal ready going inactive tells the modem to hang up.
// RQ12 - On half duplex, request-to-send sets the direction of transfer.
// RQ13 - Serial clocks are outputs from the baud generator or clock inputs.
// RQ14 - The base is a static setting compared with the upper address bits.
module iod_decode
  import iod_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [BASE_W-1:0] map_base_i,
  input wire logic bus_req_i,
  input wire logic bus_wr_i,
  input wire logic [ADDR_W-1:0] bus_addr_i,
  input wire logic [DATA_W-1:0] bus_wdata_i,
  output logic bus_ack_o,
  output logic bus_err_o,
  output logic [DATA_W-1:0] bus_rdata_o,
  output logic per_sel_o,
  output logic per_wr_o,
  output logic [7:0] per_index_o,
  output logic [7:0] per_wdata_o,
  input wire logic [7:0] per_rdata_i,
  input wire logic per_ready_i,
  input wire logic [NUM_TMR-1:0] timer_one_ext_clk_n_i,
  input wire logic [NUM_TMR-1:0] timer_one_inhibit_n_i,
  output logic [NUM_TMR-1:0] timer_ext_count_o,
  input wire logic [NUM_TMR-1:0] timer_out_i,
  input wire logic [NUM_TMR-1:0] timer_out_sel_i,
  output logic [NUM_TMR-1:0] timer_one_out_pin_o,
  input wire logic [NUM_PIO-1:0] port_one_a_ctl_in_i,
  input wire logic [NUM_PIO-1:0] port_one_b_ctl_in_i,
  output logic [NUM_PIO-1:0] handshake_line_one_o,
  output logic [NUM_PIO-1:0] handshake_line_three_o,
  input wire logic [NUM_PIO-1:0] handshake_line_two_i,
  input wire logic [NUM_PIO-1:0] handshake_line_four_i,
  output logic [NUM_PIO-1:0] port_one_a_ctl_out_o,
  output logic [NUM_PIO-1:0] port_one_b_ctl_out_o,
  input wire logic [NUM_SER-1:0] term_ready_i,
  output logic [NUM_SER-1:0] term_ready_o,
  output logic [NUM_SER-1:0] hangup_o,
  input wire logic [NUM_SER-1:0] req_send_i,
  output logic [NUM_SER-1:0] req_send_o,
  output logic [NUM_SER-1:0] tx_dir_o,
  input wire logic [NUM_SER-1:0] ser_clk_out_sel_i,
  input wire logic [NUM_SER-1:0] baud_clk_i,
  input wire logic [NUM_SER-1:0] txc_pin_i,
  input wire logic [NUM_SER-1:0] rxc_pin_i,
  output logic [NUM_SER-1:0] txc_pin_o,
  output logic [NUM_SER-1:0] txc_pin_oe_o,
  output logic [NUM_SER-1:0] rxc_pin_o,
  output logic [NUM_SER-1:0] rxc_pin_oe_o,
  output logic [NUM_SER-1:0] tx_clk_o,
  output logic [NUM_SER-1:0] rx_clk_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    iod_state_t st;
    logic base_ok;
    logic [BASE_W-1:0] base;
    logic [DATA_W-1:0] rdata;
    logic sel;
    logic wr;
    logic [7:0] index;
    logic [7:0] wdata;
    logic [NUM_TMR-1:0] clk_s1;
    logic [NUM_TMR-1:0] clk_s2;
    logic [NUM_TMR-1:0] clk_s3;
    logic [NUM_TMR-1:0] gate_s1;
    logic [NUM_TMR-1:0] gate_s2;
    logic [NUM_TMR-1:0] gate_s3;
    logic [NUM_TMR-1:0] clk_lvl;
    logic [NUM_TMR-1:0] gate_lvl;
    logic [NUM_TMR-1:0] tmr_out;
    logic [NUM_SER-1:0] dtr;
    logic [NUM_SER-1:0] hang;
  } iod_regs_t;

  iod_regs_t q;
  iod_regs_t d;

  logic hit;
  logic [MAP_OFS_W-1:0] ofs;
  logic upper;
  logic is_null;
  logic [4:0] slot;
  logic [NUM_TMR-1:0] clk_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  assign ofs = bus_addr_i[MAP_OFS_W-1:0]; // RQ5
  assign upper = ~ofs[0]; // RQ5
  // Only the four I/O blocks with null slots; others are always live
  assign slot = ofs[5:1];
  assign hit = q.base_ok
    && (bus_addr_i[ADDR_W-1:MAP_OFS_W] == q.base); // RQ6 RQ14
  always_comb begin
    is_null = 1'b0;
    if (ofs[8:1] >= PERIPH_FIRST && ofs[8:1] <= PERIPH_LAST) begin
      if (slot >= SLOT_NULL_LO && slot <= SLOT_NULL_HI) is_null = 1'b1;
      if (slot == SLOT_NULL_A || slot == SLOT_NULL_B) is_null = 1'b1;
      if (slot == SLOT_NULL_C || slot == SLOT_NULL_D) is_null = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.sel = 1'b0;
    d.clk_s1 = timer_one_ext_clk_n_i;
    d.clk_s2 = q.clk_s1;
    d.clk_s3 = q.clk_s2;
    d.gate_s1 = timer_one_inhibit_n_i;
    d.gate_s2 = q.gate_s1;
    d.gate_s3 = q.gate_s2;
    if (q.clk_s2 == q.clk_s3) d.clk_lvl = q.clk_s3;
    if (q.gate_s2 == q.gate_s3) d.gate_lvl = q.gate_s3;
    d.tmr_out = timer_out_i & timer_out_sel_i; // RQ9
    d.dtr = term_ready_i;
    d.hang = q.dtr & ~term_ready_i; // RQ11
    if (!q.base_ok) begin
      // Strap caught after release, never under reset
      d.base = map_base_i; // RQ14
      d.base_ok = 1'b1;
    end
    case (q.st)
      IOD_IDLE: begin
        if (bus_req_i && hit) begin
          d.index = ofs[8:1];
          d.wr = bus_wr_i;
          d.wdata = bus_wdata_i[7:0]; // RQ3
          d.rdata = '0;
          if (is_null) begin
            d.st = IOD_ACK; // RQ1 RQ2
          end else begin
            d.sel = 1'b1;
            d.st = IOD_WAIT;
          end
        end
      end
      IOD_WAIT: begin
        if (per_ready_i) begin
          if (!q.wr) d.rdata = {8'h00, per_rdata_i};
          d.st = IOD_ACK;
        end
      end
      IOD_ACK: begin
        d.st = IOD_IDLE;
      end
      default: begin
        d.st = IOD_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.st <= IOD_IDLE;
      q.base <= BASE_RST;
      q.clk_s1 <= '1;
      q.clk_s2 <= '1;
      q.clk_s3 <= '1;
      q.clk_lvl <= '1;
      q.gate_s1 <= '1;
      q.gate_s2 <= '1;
      q.gate_s3 <= '1;
      q.gate_lvl <= '1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign bus_ack_o = (q.st == IOD_ACK);
  assign bus_err_o = 1'b0; // RQ4
  assign bus_rdata_o = q.rdata; // RQ1
  assign per_sel_o = q.sel;
  assign per_wr_o = q.wr;
  assign per_index_o = q.index;
  assign per_wdata_o = q.wdata; // RQ3

  // Falling edge of active-low clock pin, dropped while gate held low
  assign clk_fall = q.clk_lvl & ~d.clk_lvl;
  assign timer_ext_count_o = clk_fall & q.gate_lvl; // RQ7 RQ8
  assign timer_one_out_pin_o = q.tmr_out; // RQ9

  assign handshake_line_one_o = port_one_a_ctl_in_i; // RQ10
  assign handshake_line_three_o = port_one_b_ctl_in_i; // RQ10
  assign port_one_a_ctl_out_o = handshake_line_two_i; // RQ10
  assign port_one_b_ctl_out_o = handshake_line_four_i; // RQ10

  assign term_ready_o = q.dtr; // RQ11
  assign hangup_o = q.hang; // RQ11
  assign req_send_o = req_send_i; // RQ12
  assign tx_dir_o = req_send_i; // RQ12

  // Pin driven only when the baud generator owns it
  assign txc_pin_o = baud_clk_i & ser_clk_out_sel_i; // RQ13
  assign rxc_pin_o = baud_clk_i & ser_clk_out_sel_i; // RQ13
  assign txc_pin_oe_o = ser_clk_out_sel_i; // RQ13
  assign rxc_pin_oe_o = ser_clk_out_sel_i; // RQ13
  assign tx_clk_o = (ser_clk_out_sel_i & baud_clk_i)
    | (~ser_clk_out_sel_i & txc_pin_i); // RQ13
  assign rx_clk_o = (ser_clk_out_sel_i & baud_clk_i)
    | (~ser_clk_out_sel_i & rxc_pin_i); // RQ13

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence null_take_s;
    q.st == IOD_IDLE && bus_req_i && hit && is_null;
  endsequence

  null_read_zero_a: assert property ( // RQ1
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    null_take_s ##0 !bus_wr_i |=> bus_ack_o && bus_rdata_o == 16'h0000)
    else $error("null read not zero");

  null_write_quiet_a: assert property ( // RQ2
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    null_take_s |=> !per_sel_o && bus_ack_o)
    else $error("null write reached a peripheral");

  upper_lane_a: assert property ( // RQ3
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    q.st == IOD_IDLE && bus_req_i && hit && upper && bus_wr_i && !is_null
    |=> per_sel_o && per_wdata_o == $past(bus_wdata_i[7:0]))
    else $error("upper write lost low lane");

  no_bus_err_a: assert property ( // RQ4
    @(posedge ref_clk_i) disable iff (!rst_n_i) !bus_err_o)
    else $error("bus error raised");

  index_span_a: assert property ( // RQ5
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    per_sel_o |-> per_index_o == $past(bus_addr_i[8:1]))
    else $error("index does not match offset");

  miss_ignored_a: assert property ( // RQ6
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    q.st == IOD_IDLE && bus_req_i
    && bus_addr_i[ADDR_W-1:MAP_OFS_W] != q.base |=> q.st == IOD_IDLE)
    else $error("access outside map accepted");

  gate_block_a: assert property ( // RQ8
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !q.gate_lvl[0] |-> !timer_ext_count_o[0])
    else $error("count while gated");

  hangup_pulse_a: assert property ( // RQ11
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(q.dtr[1]) |-> hangup_o[1])
    else $error("no hang-up on ready drop");

  timer_route_a: assert property ( // RQ9
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !timer_out_sel_i[1] |=> !timer_one_out_pin_o[1])
    else $error("timer output leaked");
endmodule

/* File: bench/iod_per_model.sv */
// Purpose: Peripheral responder behind the map decoder
// Assumes: One select pulse opens an access, index held to ready
// Notes: Read data scrambles between answers, it never holds
`timescale 1ns/1ps
module iod_per_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sel_i,
  input wire logic wr_i,
  input wire logic [7:0] index_i,
  input wire logic [7:0] wdata_i,
  input wire logic [3:0] lat_i,
  output logic [7:0] rdata_o,
  output logic ready_o
);
  logic [7:0] mem [256];
  logic [3:0] cnt;
  logic busy;
  ////////////////////////////////////////////////////////////////////
  // Latency set by the bench, so prompt and slow answers both occur
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
      busy <= 1'b0;
      cnt <= 4'h0;
      rdata_o <= 8'h5a;
    end else begin
      ready_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (sel_i) begin
        busy <= 1'b1;
        cnt <= lat_i;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        ready_o <= 1'b1;
        rdata_o <= mem[index_i];
        if (wr_i) mem[index_i] <= wdata_i;
      end
    end
  end
endmodule

/* File: bench/tb_iod_decode.sv */
// Purpose: Self-checking bench for the map decoder
// Assumes: Strap base 15'h0012, so the map starts at 24'h002400
// Notes: Pin paths checked by level, pulses counted per edge
`timescale 1ns/1ps
module tb_iod_decode;
  import iod_pkg::*;
  localparam logic [23:0] B = 24'h002400;
  logic clk = 0, rst_n = 0, req = 0, wr = 0, ack, err, sel, pwr, prdy;
  logic [23:0] addr = 0;
  logic [15:0] wdat = 0, rdat, r;
  logic [7:0] pidx, pwd, prd;
  logic [3:0] lat = 0;
  logic ok;
  logic [2:0] tck = '1, tgt = '1, tex, tout = 0, tsel = 0, tpin;
  logic [2:0] pa = 0, pb = 0, h1, h3, h2 = 0, h4 = 0, ca, cb;
  logic [1:0] dtr = '1, dtro, hup, rts = 0, rtso, dir, csel = 0;
  logic [1:0] baud = 0, txi = 0, rxi = 0, txo, txoe, rxo, rxoe, txc, rxc;
  int failures = 0, tests_run = 0, scnt = 0, tcn = 0, hcn = 0, ecn = 0;
  int s;
  ////////////////////////////////////////////////////////////////////
  iod_decode iod_decode_i (.ref_clk_i(clk), .rst_n_i(rst_n),
    .map_base_i(15'h0012), .bus_req_i(req), .bus_wr_i(wr),
    .bus_addr_i(addr), .bus_wdata_i(wdat), .bus_ack_o(ack),
    .bus_err_o(err), .bus_rdata_o(rdat), .per_sel_o(sel),
    .per_wr_o(pwr), .per_index_o(pidx), .per_wdata_o(pwd),
    .per_rdata_i(prd), .per_ready_i(prdy), .timer_one_ext_clk_n_i(tck),
    .timer_one_inhibit_n_i(tgt), .timer_ext_count_o(tex),
    .timer_out_i(tout), .timer_out_sel_i(tsel),
    .timer_one_out_pin_o(tpin), .port_one_a_ctl_in_i(pa),
    .port_one_b_ctl_in_i(pb), .handshake_line_one_o(h1),
    .handshake_line_three_o(h3), .handshake_line_two_i(h2),
    .handshake_line_four_i(h4), .port_one_a_ctl_out_o(ca),
    .port_one_b_ctl_out_o(cb), .term_ready_i(dtr), .term_ready_o(dtro),
    .hangup_o(hup), .req_send_i(rts), .req_send_o(rtso), .tx_dir_o(dir),
    .ser_clk_out_sel_i(csel), .baud_clk_i(baud), .txc_pin_i(txi),
    .rxc_pin_i(rxi), .txc_pin_o(txo), .txc_pin_oe_o(txoe),
    .rxc_pin_o(rxo), .rxc_pin_oe_o(rxoe), .tx_clk_o(txc), .rx_clk_o(rxc));
  iod_per_model iod_per_model_i (.clk_i(clk), .rst_n_i(rst_n),
    .sel_i(sel), .wr_i(pwr), .index_i(pidx), .wdata_i(pwd), .lat_i(lat),
    .rdata_o(prd), .ready_o(prdy));
  ////////////////////////////////////////////////////////////////////
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (sel === 1'b1) scnt <= scnt + 1;
    if (tex[0] === 1'b1) tcn <= tcn + 1;
    if (hup[1] === 1'b1) hcn <= hcn + 1;
    if (err !== 1'b0 && rst_n) ecn <= ecn + 1;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Request held until ack is seen or 12 cycles pass, dropped in the ack cycle
  task bus(input logic w, input logic [23:0] a, input logic [15:0] d);
    ok = 0;
    req = 1;
    wr = w;
    addr = a;
    wdat = d;
    for (int i = 0; i < 12 && !ok; i++) begin
      tick(1);
      ok = (ack === 1'b1);
      r = rdat;
    end
    req = 0;
    tick(1);
  endtask
  ////////////////////////////////////////////////////////////////////
  task t_null;
    s = scnt;
    bus(0, B + 24'h9f, 16'h0);
    chk(ok, 1);
    chk(r, 0);
    bus(1, B + 24'h9e, 16'h1234);
    chk(ok, 1);
    chk(16'(scnt - s), 0);
    $display("test null done");
  endtask
  task t_upper;
    lat = 4'h5;
    bus(1, B + 24'h90, 16'hab5c);
    chk(ok, 1);
    lat = 4'h0;
    bus(0, B + 24'h90, 16'h0);
    chk(r, 16'h005c);
    chk(16'(ecn), 0);
    $display("test upper done");
  endtask
  task t_reloc;
    s = scnt;
    bus(0, 24'hff0090, 16'h0);
    chk(ok, 0);
    bus(0, B + 24'h200, 16'h0);
    chk(ok, 0);
    bus(0, B - 24'h1, 16'h0);
    chk(ok, 0);
    chk(16'(scnt - s), 0);
    $display("test reloc done");
  endtask
  task t_pins;
    pa = 3'b101;
    pb = 3'b010;
    h2 = 3'b011;
    h4 = 3'b110;
    rts = 2'b10;
    tout = 3'b111;
    tsel = 3'b101;
    csel = 2'b01;
    baud = 2'b11;
    tick(3);
    chk({h1, h3, ca, cb}, 12'ha9e);
    chk({rtso, dir}, 4'ha);
    chk(tpin, 3'b101);
    chk({txoe, rxoe, txo, rxo, txc, rxc}, 12'h555);
    baud = 2'b00;
    txi = 2'b10;
    rxi = 2'b11;
    #1;
    chk({txc, rxc}, 4'ha);
    $display("test pins done");
  endtask
  task t_count;
    s = tcn;
    tck[0] = 0;
    tick(8);
    tck[0] = 1;
    tick(8);
    chk(16'(tcn - s), 1);
    tgt[0] = 0;
    tick(8);
    s = tcn;
    tck[0] = 0;
    tick(8);
    tck[0] = 1;
    tick(8);
    chk(16'(tcn - s), 0);
    s = hcn;
    dtr[1] = 0;
    tick(6);
    chk(16'(hcn - s), 1);
    chk(dtro, 2'b01);
    $display("test count done");
  endtask
  task stop_test;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    stop_test;
  end
  initial begin
    tick(3);
    rst_n = 1;
    tick(2);
    t_null;
    t_upper;
    t_reloc;
    t_pins;
    t_count;
    stop_test;
  end
endmodule
